/* File: pkg/usart_tx_pkg.sv */
// shared constants, enumerations and carrier structs of the serial transmitter
package usart_tx_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ           = 100_000_000;
   localparam int unsigned EXT_SCK_MAX_HZ   = 1_000_000;
   // least system cycles per external clock half period
   localparam int unsigned EXT_SCK_MIN_HALF = CLK_HZ / (2 * EXT_SCK_MAX_HZ);
   localparam logic [3:0]  OVS_LAST_NORMAL  = 4'hf; // 16 samples per bit
   localparam logic [3:0]  OVS_LAST_DOUBLE  = 4'h7; // 8 samples per bit

   // ----------------------------------------------------------------
   // sizes and field positions
   // ----------------------------------------------------------------
   localparam int unsigned BAUD_W_DEF     = 8;
   localparam int unsigned FIFO_DEPTH_DEF = 32;
   localparam int unsigned WORD_W         = 9;
   localparam logic [3:0]  WORD_BITS      = 4'h9;
   localparam logic [2:0]  CHAR_5BIT      = 3'h0;
   localparam logic [2:0]  CHAR_6BIT      = 3'h1;
   localparam logic [2:0]  CHAR_7BIT      = 3'h2;
   localparam logic [2:0]  CHAR_9BIT      = 3'h7;
   localparam int unsigned PAR_EN_POS     = 1;
   localparam int unsigned PAR_ODD_POS    = 0;
   localparam logic        LINE_IDLE      = 1'b1;
   localparam logic        LINE_START     = 1'b0;

   // ----------------------------------------------------------------
   // enumerations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_ASYNC = 2'b00,
      MODE_SYNC  = 2'b01,
      MODE_I2C   = 2'b10,
      MODE_SPI   = 2'b11
   } op_mode_e;

   typedef enum logic [2:0] {
      TX_IDLE   = 3'b000,
      TX_START  = 3'b001,
      TX_DATA   = 3'b010,
      TX_PARITY = 3'b011,
      TX_STOP1  = 3'b100,
      TX_STOP2  = 3'b101
   } tx_state_e;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      op_mode_e   op_mode_sel;
      logic       double_speed;
      logic       clock_master_sel;
      logic       clock_edge_sel;
      logic [2:0] char_size_sel;
      logic [1:0] parity_mode_sel;
      logic       stop_bits_sel;
   } serial_cfg_s;

   typedef struct packed {
      logic tx_buffer_empty_flag;
      logic tx_complete_flag;
   } flag_bits_s;

   typedef struct packed {
      logic tx_empty_irq_enable;
      logic tx_complete_irq_enable;
      logic global_irq_enable;
   } irq_ctrl_s;

   typedef struct packed {
      logic bit_tick;
      logic rise;
      logic fall;
      logic sck;
   } clk_evt_s;

endpackage

/* File: verilog/usart_tx_fifo.sv */
// transmit buffer fifo with registered head word
`timescale 1ns/1ps
module usart_tx_fifo
   import usart_tx_pkg::*;
#(
   parameter int unsigned W     = WORD_W,
   parameter int unsigned DEPTH = FIFO_DEPTH_DEF
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   // fill side
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output      logic         in_ready_o,
   // drain side
   output      logic         out_valid_o,
   output      logic [W-1:0] out_data_o,
   input  wire logic         out_ready_i,
   // any word held anywhere
   output      logic         occupied_o
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
      logic                    ov;
      logic [W-1:0]            od;
      logic                    rdy;
      logic                    occ;
   } st_s;

   localparam st_s ST_RST = '{rdy: 1'b1, default: '0};

   st_s  q;
   st_s  next_q;
   logic push;
   logic load;

   // push into storage, refill the head register when it empties
   always_comb begin
      next_q = q;
      push   = in_valid_i && q.rdy;
      load   = (q.cnt != '0) && (!q.ov || out_ready_i);
      if (q.ov && out_ready_i) begin
         next_q.ov = 1'b0;
      end
      if (push) begin
         next_q.mem[q.wp] = in_data_i;
         next_q.wp        = q.wp + 1'b1;
      end
      if (load) begin
         next_q.od = q.mem[q.rp];
         next_q.ov = 1'b1;
         next_q.rp = q.rp + 1'b1;
      end
      next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(load);
      // the head register counts toward the depth, so never more than DEPTH words are held
      next_q.rdy = (next_q.cnt + (AW+1)'(next_q.ov)) != FULL_CNT;
      next_q.occ = (next_q.cnt != '0) || next_q.ov;
   end

   // state register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         q <= ST_RST;
      end else begin
         q <= next_q;
      end
   end

   assign in_ready_o  = q.rdy;
   assign out_valid_o = q.ov;
   assign out_data_o  = q.od;
   assign occupied_o  = q.occ;
endmodule // usart_tx_fifo

/* File: verilog/usart_clock_gen.sv */
// baud generator and external serial clock synchroniser
`timescale 1ns/1ps
module usart_clock_gen
   import usart_tx_pkg::*;
#(
   parameter int unsigned BAUD_W = BAUD_W_DEF
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   // configuration
   input  wire serial_cfg_s       cfg_i,
   input  wire logic [BAUD_W-1:0] baud_divisor_i,
   // external clock pin
   input  wire logic              serial_clock_i,
   // registered clock events
   output      clk_evt_s          evt_o
);
   typedef struct packed {
      logic [BAUD_W-1:0] pre;
      logic [3:0]        ovs;
      logic              sck;
      logic              s1;
      logic              s2;
      logic              s3;
      logic              lvl;
      clk_evt_s          evt;
   } st_s;

   st_s        q;
   st_s        next_q;
   logic       wrap;
   logic       sync_mode;
   logic [3:0] ovs_last;

   // prescaler, oversample counter, master clock and slave edge detect
   always_comb begin
      next_q     = q;
      next_q.evt = '0;
      sync_mode  = (cfg_i.op_mode_sel == MODE_SYNC) || (cfg_i.op_mode_sel == MODE_SPI);
      ovs_last   = cfg_i.double_speed ? OVS_LAST_DOUBLE : OVS_LAST_NORMAL;
      wrap       = q.pre >= baud_divisor_i;
      next_q.pre = wrap ? '0 : q.pre + 1'b1;
      next_q.s1  = serial_clock_i;
      next_q.s2  = q.s1;
      next_q.s3  = q.s2;
      if (q.s2 == q.s3) begin
         next_q.lvl = q.s3;
      end
      if (!sync_mode) begin
         if (wrap) begin
            next_q.ovs          = (q.ovs >= ovs_last) ? '0 : q.ovs + 1'b1;
            next_q.evt.bit_tick = q.ovs >= ovs_last;
         end
      end else if (cfg_i.clock_master_sel) begin
         if (wrap) begin
            next_q.sck      = ~q.sck;
            next_q.evt.rise = ~q.sck;
            next_q.evt.fall = q.sck;
         end
      end else begin
         next_q.sck      = next_q.lvl;
         next_q.evt.rise = next_q.lvl & ~q.lvl;
         next_q.evt.fall = ~next_q.lvl & q.lvl;
      end
      next_q.evt.sck = next_q.sck;
   end

   // state register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign evt_o = q.evt;
endmodule // usart_clock_gen

/* File: verilog/usart_clock_frame_transmitter.sv */
// serial transmitter: clocking, frame format, parity, buffer and flags
// What this block does
// - two-bit mode field picks asynchronous, synchronous or spi operation; i2c holds the transmitter idle
// - asynchronous normal bit rate is fx over 16 times divisor plus one
// - double speed bit rate is fx over 8 times divisor plus one
// - master serial clock is fx over 2 times divisor plus one
// - external clock is synchronised and edge detected; peer keeps it under 1 MHz
// - synchronous data changes on one clock edge; edge select zero means rising
// - in synchronous and spi modes the master bit drives the clock pin out, otherwise it is an input
// - frames: start, five to nine data, optional parity, one or two stops
// - data leaves least significant bit first after the start bit
// - line idles high; a falling edge starts a frame
// - next frame follows with no gap, or the line goes idle
// - even parity is xor of data bits, odd parity its inverse
// - parity bit sits between last data bit and first stop bit
// - one frame format setting serves both directions
// - transmitter starts frames only while its enable is set
// - data write fills buffer; shifter loads when idle or after last stop
// - buffer empty flag follows the buffer; writing zero clears it
// - buffer empty interrupt while flag, enable and global enable are set
// - complete flag sets when frame is out and buffer holds nothing
// - complete flag clears on interrupt service or on writing zero
// - complete interrupt while flag, enable and global enable are set
// - disabling waits for the frame in flight; pin then released
// - parity inserted only when the upper parity mode bit is one
`timescale 1ns/1ps
module usart_clock_frame_transmitter
   import usart_tx_pkg::*;
#(
   parameter int unsigned BAUD_W     = BAUD_W_DEF,
   parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   // configuration
   input  wire serial_cfg_s       cfg_i,
   input  wire logic [BAUD_W-1:0] baud_divisor_i,
   input  wire logic              tx_enable_i,
   // data buffer write
   input  wire logic              data_buffer_wr_i,
   input  wire logic [7:0]        data_buffer_i,
   input  wire logic              tx_ninth_bit_i,
   output      logic              data_ready_o,
   // flags and interrupts
   input  wire logic              flag_wr_i,
   input  wire flag_bits_s        flag_wdata_i,
   input  wire irq_ctrl_s         irq_ctrl_i,
   input  wire logic              tx_complete_ack_i,
   output      logic              tx_buffer_empty_flag_o,
   output      logic              tx_complete_flag_o,
   output      logic              tx_empty_irq_o,
   output      logic              tx_complete_irq_o,
   // pins
   output      logic              serial_out_pin_o,
   output      logic              serial_out_pin_oe_o,
   input  wire logic              serial_clock_pin_i,
   output      logic              serial_clock_pin_o,
   output      logic              serial_clock_pin_oe_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      tx_state_e         state;
      logic [WORD_W-1:0] shreg;
      logic [3:0]        bitn;
      logic [3:0]        nbits;
      logic              par_en;
      logic              par_bit;
      logic              two_stop;
      logic              xacc;
      logic              txd;
      logic              txd_oe;
      logic              sck;
      logic              sck_oe;
      logic              occ_d;
      logic              dre;
      logic              txc;
      logic              irq_dre;
      logic              irq_txc;
   } st_s;

   localparam st_s ST_RST = '{state: TX_IDLE, txd: LINE_IDLE, dre: 1'b1, default: '0};

   st_s               q;
   st_s               next_q;
   clk_evt_s          evt;
   logic              fifo_valid;
   logic [WORD_W-1:0] fifo_word;
   logic              fifo_occ;
   logic              fifo_pop;
   logic              frame_done;
   logic              sync_mode;
   logic              adv;
   logic              start_ok;
   logic [3:0]        load_bits;
   logic [WORD_W-1:0] load_mask;
   logic              dre_clr;
   logic              txc_set;
   logic              txc_clr;

   // ----------------------------------------------------------------
   // clocking and buffer
   // ----------------------------------------------------------------
   // baud generator and external clock synchroniser
   usart_clock_gen #(
      .BAUD_W (BAUD_W)
   ) u_clock_gen (
      .clk_i          (clk_i),
      .sys_rst_i      (sys_rst_i),
      .cfg_i          (cfg_i),
      .baud_divisor_i (baud_divisor_i),
      .serial_clock_i (serial_clock_pin_i),
      .evt_o          (evt)
   );

   // transmit buffer, ninth bit captured with the low byte
   usart_tx_fifo #(
      .W     (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .in_valid_i  (data_buffer_wr_i),
      .in_data_i   ({tx_ninth_bit_i, data_buffer_i}),
      .in_ready_o  (data_ready_o),
      .out_valid_o (fifo_valid),
      .out_data_o  (fifo_word),
      .out_ready_i (fifo_pop),
      .occupied_o  (fifo_occ)
   );

   // mode decode and the bit advance event
   assign sync_mode = (cfg_i.op_mode_sel == MODE_SYNC) ||
                      (cfg_i.op_mode_sel == MODE_SPI);
   assign adv = sync_mode ? (cfg_i.clock_edge_sel ? evt.fall : evt.rise)
                          : evt.bit_tick;
   assign start_ok = tx_enable_i && fifo_valid &&
                     (cfg_i.op_mode_sel != MODE_I2C);

   // data bit count from the shared character size field
   always_comb begin
      unique case (cfg_i.char_size_sel)
         CHAR_5BIT: load_bits = 4'h5;
         CHAR_6BIT: load_bits = 4'h6;
         CHAR_7BIT: load_bits = 4'h7;
         CHAR_9BIT: load_bits = WORD_BITS;
         default:   load_bits = 4'h8;
      endcase
      load_mask = {WORD_W{1'b1}} >> (WORD_BITS - load_bits);
   end

   // ----------------------------------------------------------------
   // frame sequencer and flags
   // ----------------------------------------------------------------
   always_comb begin
      next_q     = q;
      frame_done = 1'b0;
      fifo_pop   = 1'b0;
      unique case (q.state)
         TX_IDLE: begin
            if (adv && start_ok) begin
               fifo_pop     = 1'b1;
               next_q.state = TX_START;
            end
         end
         TX_START: begin
            if (adv) begin
               next_q.state = TX_DATA;
               next_q.bitn  = '0;
               next_q.xacc  = 1'b0;
            end
         end
         TX_DATA: begin
            if (adv) begin
               next_q.xacc  = q.xacc ^ q.shreg[0];
               next_q.shreg = q.shreg >> 1;
               next_q.bitn  = q.bitn + 1'b1;
               if (q.bitn == q.nbits - 1'b1) begin
                  next_q.state = q.par_en ? TX_PARITY : TX_STOP1;
               end
            end
         end
         TX_PARITY: begin
            if (adv) begin
               next_q.state = TX_STOP1;
            end
         end
         TX_STOP1: begin
            if (adv) begin
               if (q.two_stop) begin
                  next_q.state = TX_STOP2;
               end else begin
                  frame_done = 1'b1;
               end
            end
         end
         TX_STOP2: begin
            if (adv) begin
               frame_done = 1'b1;
            end
         end
         default: begin
            next_q.state = TX_IDLE;
         end
      endcase

      // back to back frame or idle once the last stop bit ends
      if (frame_done) begin
         if (start_ok) begin
            fifo_pop     = 1'b1;
            next_q.state = TX_START;
         end else begin
            next_q.state = TX_IDLE;
         end
      end

      // load the shifter and latch the format for this frame
      if (fifo_pop) begin
         next_q.shreg    = fifo_word & load_mask;
         next_q.nbits    = load_bits;
         next_q.par_en   = cfg_i.parity_mode_sel[PAR_EN_POS];
         next_q.par_bit  = (^(fifo_word & load_mask)) ^
                           cfg_i.parity_mode_sel[PAR_ODD_POS];
         next_q.two_stop = cfg_i.stop_bits_sel;
      end

      // line level follows the next state
      unique case (next_q.state)
         TX_START:  next_q.txd = LINE_START;
         TX_DATA:   next_q.txd = next_q.shreg[0];
         TX_PARITY: next_q.txd = next_q.par_bit;
         default:   next_q.txd = LINE_IDLE;
      endcase
      next_q.txd_oe = tx_enable_i || (next_q.state != TX_IDLE);

      // serial clock pin
      next_q.sck    = evt.sck;
      next_q.sck_oe = sync_mode && cfg_i.clock_master_sel;

      // buffer empty flag: emptying wins over a software clear
      next_q.occ_d = fifo_occ;
      dre_clr      = flag_wr_i && !flag_wdata_i.tx_buffer_empty_flag;
      if (fifo_occ) begin
         next_q.dre = 1'b0;
      end else if (q.occ_d) begin
         next_q.dre = 1'b1;
      end else if (dre_clr) begin
         next_q.dre = 1'b0;
      end

      // transmit complete flag: set wins over clear
      txc_set    = frame_done && !fifo_occ && !fifo_pop;
      txc_clr    = tx_complete_ack_i ||
                   (flag_wr_i && !flag_wdata_i.tx_complete_flag);
      next_q.txc = txc_set || (q.txc && !txc_clr);

      // interrupt requests
      next_q.irq_dre = next_q.dre && irq_ctrl_i.tx_empty_irq_enable &&
                       irq_ctrl_i.global_irq_enable;
      next_q.irq_txc = next_q.txc && irq_ctrl_i.tx_complete_irq_enable &&
                       irq_ctrl_i.global_irq_enable;
   end

   // state register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         q <= ST_RST;
      end else begin
         q <= next_q;
      end
   end

   // outputs
   assign serial_out_pin_o       = q.txd;
   assign serial_out_pin_oe_o    = q.txd_oe;
   assign serial_clock_pin_o     = q.sck;
   assign serial_clock_pin_oe_o  = q.sck_oe;
   assign tx_buffer_empty_flag_o = q.dre;
   assign tx_complete_flag_o     = q.txc;
   assign tx_empty_irq_o         = q.irq_dre;
   assign tx_complete_irq_o      = q.irq_txc;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   // start of a frame drives the line low
   frame_start_a: assert property ($rose(q.state == TX_START) |->
      !serial_out_pin_o)
      else $error("start bit not low");

   // idle and stop periods keep the line high
   line_high_a: assert property ((q.state inside {TX_IDLE, TX_STOP1, TX_STOP2})
      |-> serial_out_pin_o)
      else $error("line not high outside data");

   // parity bit matches the data bits sent
   parity_bit_a: assert property ((q.state == TX_PARITY) |->
      serial_out_pin_o == (q.xacc ^ cfg_i.parity_mode_sel[PAR_ODD_POS]))
      else $error("parity bit wrong");

   // no parity state without parity enabled
   parity_skip_a: assert property ((q.state == TX_DATA) && !q.par_en
      |=> q.state != TX_PARITY)
      else $error("parity inserted while disabled");

   // a waiting word follows the last stop bit with no gap
   no_gap_a: assert property (frame_done && start_ok |=>
      (q.state == TX_START) && !serial_out_pin_o)
      else $error("gap between frames");

   // frame end with empty buffer raises complete flag
   txc_set_a: assert property (frame_done && !fifo_occ |=>
      tx_complete_flag_o)
      else $error("complete flag not set");

   // service clears complete flag unless a frame ends in the same cycle
   txc_clear_a: assert property (tx_complete_ack_i && !frame_done |=>
      !tx_complete_flag_o)
      else $error("complete flag not cleared");

   // buffer holding data keeps empty flag low
   dre_busy_a: assert property (fifo_occ |=> !tx_buffer_empty_flag_o)
      else $error("empty flag set while buffer full");

   // interrupt requests follow their flags
   dre_irq_a: assert property (tx_empty_irq_o |->
      tx_buffer_empty_flag_o && $past(irq_ctrl_i.global_irq_enable))
      else $error("empty interrupt without flag");

   txc_irq_a: assert property (tx_complete_flag_o &&
      $past(irq_ctrl_i.tx_complete_irq_enable && irq_ctrl_i.global_irq_enable)
      |-> tx_complete_irq_o)
      else $error("complete interrupt missing");

   // pin stays driven until the frame in flight ends
   disable_wait_a: assert property ((q.state != TX_IDLE) |->
      serial_out_pin_oe_o)
      else $error("pin released mid frame");

   // clock pin driven only as master in synchronous or spi mode
   sck_dir_a: assert property (serial_clock_pin_oe_o |->
      $past(sync_mode && cfg_i.clock_master_sel))
      else $error("clock pin driven outside master");

   // main scenarios
   back_to_back_c: cover property (frame_done && start_ok);
   parity_frame_c: cover property (q.state == TX_PARITY ##1 q.state == TX_STOP1);
   two_stop_c: cover property (q.state == TX_STOP2);
   sync_frame_c: cover property (sync_mode && (q.state == TX_START));
endmodule // usart_clock_frame_transmitter

/* File: test/uart_peer.sv */
// serial line listener that decodes one frame per start edge
`timescale 1ns/1ps
module uart_peer (
   // clock, line and frame shape
   input  wire logic       clk_i,
   input  wire logic       line_i,
   input  wire logic [31:0] per_i,
   input  wire logic [31:0] nbits_i,
   input  wire logic       par_i,
   input  wire logic       stop2_i,
   // decoded frame
   output      logic [8:0] word_o = 9'h000,
   output      logic       par_o = 1'b0,
   output      logic [1:0] stop_o = 2'h0,
   output      int         cnt_o = 0
);
   // sample every bit in its middle
   initial begin
      forever begin
         @(negedge line_i);
         repeat (per_i / 2) @(posedge clk_i);
         word_o = 9'h000;
         for (int i = 0; i < nbits_i; i++) begin
            repeat (per_i) @(posedge clk_i);
            word_o[i] = line_i;
         end
         if (par_i) begin
            repeat (per_i) @(posedge clk_i);
            par_o = line_i;
         end
         repeat (per_i) @(posedge clk_i);
         stop_o = {1'b1, line_i};
         if (stop2_i) begin
            repeat (per_i) @(posedge clk_i);
            stop_o[1] = line_i;
         end
         cnt_o++;
      end
   end
endmodule // uart_peer

/* File: test/usart_clock_frame_transmitter_test.sv */
// self-checking bench for the serial transmitter
`timescale 1ns/1ps
module usart_clock_frame_transmitter_test
   import usart_tx_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   serial_cfg_s cfg = '0;
   logic [7:0]  bd = 8'h00, db = 8'h00;
   logic        ten = 1'b0, wr = 1'b0, n9 = 1'b0, fw = 1'b0, ack = 1'b0, xck = 1'b0;
   flag_bits_s  fwd = 2'h3;
   irq_ctrl_s   irq = 3'h7;
   logic        dr, ef, cf, ei, ci, so, soe, sck, sck_oe, hp = 1'b0, s2 = 1'b0;
   logic [8:0]  word;
   logic        par;
   logic [1:0]  stp;
   int          cnt, per = 16, nb = 8, n_errors = 0, total_checks = 0;
   // size code, bits, parity, two stops, double speed, divisor, word
   int t[5][7] = '{'{0, 5, 2, 0, 0, 0, 'h15}, '{1, 6, 3, 1, 0, 1, 'h2d},
      '{2, 7, 0, 0, 1, 0, 'h55}, '{3, 8, 2, 1, 0, 0, 'ha5}, '{7, 9, 3, 0, 0, 0, 'h1c3}};
   // 100 MHz clock
   always #5 clk_i = ~clk_i;
   usart_clock_frame_transmitter uut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_i(cfg), .baud_divisor_i(bd),
      .tx_enable_i(ten), .data_buffer_wr_i(wr), .data_buffer_i(db), .tx_ninth_bit_i(n9),
      .data_ready_o(dr), .flag_wr_i(fw), .flag_wdata_i(fwd), .irq_ctrl_i(irq),
      .tx_complete_ack_i(ack), .tx_buffer_empty_flag_o(ef), .tx_complete_flag_o(cf),
      .tx_empty_irq_o(ei), .tx_complete_irq_o(ci), .serial_out_pin_o(so),
      .serial_out_pin_oe_o(soe), .serial_clock_pin_i(xck), .serial_clock_pin_o(sck),
      .serial_clock_pin_oe_o(sck_oe));
   uart_peer peer (.clk_i(clk_i), .line_i(so), .per_i(per), .nbits_i(nb), .par_i(hp),
      .stop2_i(s2), .word_o(word), .par_o(par), .stop_o(stp), .cnt_o(cnt));
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic send(input logic [8:0] w);
      @(posedge clk_i);
      wr <= 1'b1;
      {n9, db} <= w;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic wait_rx(input int c);
      for (int k = 0; k < 9000 && cnt < c; k++) @(posedge clk_i);
   endtask
   // main sequence
   initial begin
      logic [8:0] w;
      int c;
      repeat (6) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      chk({ef, cf, dr, soe}, 4'ha);
      ten <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         cfg.char_size_sel <= 3'(t[i][0]);
         cfg.parity_mode_sel <= 2'(t[i][2]);
         cfg.stop_bits_sel <= t[i][3][0];
         cfg.double_speed <= t[i][4][0];
         bd <= 8'(t[i][5]);
         nb = t[i][1];
         hp = t[i][2][1];
         s2 = t[i][3][0];
         per = (t[i][4] ? 8 : 16) * (t[i][5] + 1);
         w = 9'(t[i][6]);
         c = cnt;
         send(w);
         wait_rx(c + 1);
         chk(word, w & 9'((1 << nb) - 1));
         if (hp) chk(par, ^word ^ t[i][2][0]);
         chk(stp, 2'h3);
         repeat (per) @(posedge clk_i);
         chk({cf, ci, ei}, 3'h7);
         if (i[0]) ack <= 1'b1;
         else {fw, fwd} <= 3'h6;
         @(posedge clk_i) {ack, fw} <= 2'h0;
         repeat (2) @(posedge clk_i);
         chk({cf, ci, ef}, 3'h1);
      end
      {fw, fwd} <= 3'h5;
      @(posedge clk_i) fw <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({ef, ei}, 2'h0);
      ten <= 1'b0;
      c = cnt;
      for (int i = 0; i < 33; i++) send(9'(i));
      chk({dr, soe, ef}, 3'h0);
      ten <= 1'b1;
      wait_rx(c + 32);
      ten <= 1'b0;
      chk(word, 9'h01f);
      repeat (4) @(posedge clk_i);
      chk(soe, 1'b1);
      repeat (2 * per) @(posedge clk_i);
      chk(9'(cnt - c), 9'h020);
      chk({ef, cf, soe}, 3'h6);
      ten <= 1'b1;
      cfg.op_mode_sel <= MODE_I2C;
      c = cnt;
      send(9'h0aa);
      repeat (400) @(posedge clk_i);
      chk(9'(cnt - c), 9'h000);
      cfg.op_mode_sel <= MODE_SYNC;
      cfg.clock_master_sel <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk(sck_oe, 1'b1);
      c = 0;
      w[0] = sck;
      for (int k = 0; k < 20; k++) begin
         @(posedge clk_i);
         if (sck !== w[0]) c++;
         w[0] = sck;
      end
      chk(9'(c), 9'h014);
      // let the pending master frame and the listener finish first
      repeat (200) @(posedge clk_i);
      cfg.clock_master_sel <= 1'b0;
      cfg.clock_edge_sel <= 1'b1;
      cfg.op_mode_sel <= MODE_SPI;
      repeat (4) @(posedge clk_i);
      chk(sck_oe, 1'b0);
      // slave frame clocked by an external 1 MHz clock, data on falling edges
      per = int'(2 * EXT_SCK_MIN_HALF);
      c = cnt;
      send(9'h0b4);
      for (int k = 0; k < 14; k++) begin
         repeat (EXT_SCK_MIN_HALF) @(posedge clk_i);
         xck <= 1'b1;
         repeat (EXT_SCK_MIN_HALF) @(posedge clk_i);
         xck <= 1'b0;
      end
      chk(word, 9'h0b4);
      chk(9'(cnt - c), 9'h001);
      // global enable off masks both interrupt requests
      irq <= 3'h6;
      repeat (2) @(posedge clk_i);
      chk({ei, ci}, 2'h0);
      stop_test();
   end
   // watchdog against a hang
   initial begin
      repeat (30000) @(posedge clk_i);
      n_errors++;
      stop_test();
   end
endmodule // usart_clock_frame_transmitter_test
